//--- core/prt_timer.sv
// Prescaled reload timer: 8-bit prescaler feeding an 8-bit down counter, APB slave.
// Assumes MCLK at 20 MHz, synchronous SYS_RST, ring clock and timer pin asynchronous.
//
// Behaviour
// - Timer is an 8-bit down counter fed through an 8-bit prescaler.
// - Prescaler and timer each have their own reload register and counter.
// - Each stage's reload and counter share one register address.
// - Counting and underflow reloads happen on source ticks, or on active pin edges in event mode.
// - Two-bit source field: 00 undivided, 01 div8, 10 ring clock, 11 div2.
// - Timer underflow is offered to the sibling timer when its field is 10.
// - Plain timer mode counts the internal source; pin edges only raise the external request.
// - Pulse output mode inverts the pin level on every timer underflow.
// - Event counter mode decrements on active edges at the pin.
// - Width mode counts the internal source while the input pulse is active.
// - Period mode counts the internal source between successive active edges.
// - Changing edge polarity may raise a spurious external request; tolerated.
// - Unit runs independently of other timers except optional underflow chaining.
// - On underflow the counter reloads from its reload register and continues.
// - Every timer underflow sets the underflow status bit; the interrupt request rises only when its mask bit is set.
// - A write while halted loads both reload register and counter.
// - Underflow period is (prescaler+1)*(timer+1) source ticks.
`timescale 1ns/1ns
module prt_timer (
  // Clock and reset
  input wire logic MCLK,
  input wire logic SYS_RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [prt_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Low-speed ring clock, asynchronous
  input wire logic RING_CLK,
  // Timer pin, two-way
  input wire logic TIO_IN,
  output logic TIO_OUT,
  output logic TIO_OE,
  // Events
  output logic IRQ,
  output logic EXT_IRQ1,
  output logic UNDERFLOW,
  // Sibling timer source
  output logic SIB_SRC_TICK,
  output logic [1:0] SIB_SRC_SEL
);

  function automatic logic is_reg(input logic [prt_pkg::ADDR_W-1:0] a, input logic [7:0] idx);
    is_reg = (a == {2'h0, idx, 2'h0});
  endfunction : is_reg

  // Bus-side state
  logic [7:0] mode_reg;
  logic [7:0] src_reg;
  logic [prt_pkg::ST_W-1:0] mask;
  logic pready;
  logic pslverr;
  logic [31:0] prdata;
  logic [7:0] next_mode_reg;
  logic [7:0] next_src_reg;
  logic [prt_pkg::ST_W-1:0] next_mask;
  logic next_pready;
  logic next_pslverr;
  logic [31:0] next_prdata;

  // Core state
  logic [7:0] pre_rl;
  logic [7:0] pre_cnt;
  logic [7:0] tmr_rl;
  logic [7:0] tmr_cnt;
  logic [7:0] cap;
  logic [prt_pkg::ST_W-1:0] status;
  logic [2:0] div;
  logic tio_s1;
  logic tio_s2;
  logic act_d;
  logic ring_s1;
  logic ring_s2;
  logic ring_d;
  logic tio_out;
  logic tio_oe;
  logic irq;
  logic ext_irq;
  logic uf_out;
  logic sib_tick;
  logic [7:0] next_pre_rl;
  logic [7:0] next_pre_cnt;
  logic [7:0] next_tmr_rl;
  logic [7:0] next_tmr_cnt;
  logic [7:0] next_cap;
  logic [prt_pkg::ST_W-1:0] next_status;
  logic [2:0] next_div;
  logic next_act_d;
  logic next_tio_out;
  logic next_tio_oe;
  logic next_irq;
  logic next_ext_irq;
  logic next_uf_out;
  logic next_sib_tick;

  // Shared decode
  logic xfer;
  logic wr;
  logic hit;
  logic run;
  logic [1:0] mode;
  logic period;
  logic act;

  assign xfer = PSEL & PENABLE & pready;
  assign wr = xfer & PWRITE;
  assign hit = is_reg(PADDR, prt_pkg::IDX_MODE) | is_reg(PADDR, prt_pkg::IDX_PRE) |
               is_reg(PADDR, prt_pkg::IDX_TMR) | is_reg(PADDR, prt_pkg::IDX_SRC) |
               is_reg(PADDR, prt_pkg::IDX_STAT) | is_reg(PADDR, prt_pkg::IDX_MASK);
  assign run = mode_reg[prt_pkg::RUN_BIT];
  assign mode = mode_reg[prt_pkg::MODE_LSB +: 2];
  assign period = mode_reg[prt_pkg::PER_BIT] & (mode == prt_pkg::MODE_TIMER);
  // Polarity bit folds into the level, so a polarity change looks like an edge
  assign act = tio_s2 ^ mode_reg[prt_pkg::EDGE_BIT];

  // Bus: one wait state, registered answer
  always_comb begin
    next_mode_reg = mode_reg;
    next_src_reg = src_reg;
    next_mask = mask;
    next_pready = PSEL & PENABLE & ~pready;
    next_pslverr = PSEL & PENABLE & ~pready & ~hit;
    next_prdata = 32'h0;
    if (PSEL & PENABLE & ~pready & ~PWRITE) begin
      if (is_reg(PADDR, prt_pkg::IDX_MODE)) begin
        next_prdata = {24'h0, mode_reg};
      end
      if (is_reg(PADDR, prt_pkg::IDX_PRE)) begin
        next_prdata = {24'h0, pre_cnt};
      end
      if (is_reg(PADDR, prt_pkg::IDX_TMR)) begin
        next_prdata = {24'h0, (period | mode == prt_pkg::MODE_WIDTH) ? cap : tmr_cnt};
      end
      if (is_reg(PADDR, prt_pkg::IDX_SRC)) begin
        next_prdata = {24'h0, src_reg};
      end
      if (is_reg(PADDR, prt_pkg::IDX_STAT)) begin
        next_prdata = {29'h0, status};
      end
      if (is_reg(PADDR, prt_pkg::IDX_MASK)) begin
        next_prdata = {29'h0, mask};
      end
    end
    if (wr & is_reg(PADDR, prt_pkg::IDX_MODE)) begin
      next_mode_reg = PWDATA[7:0];
    end
    if (wr & is_reg(PADDR, prt_pkg::IDX_SRC)) begin
      next_src_reg = PWDATA[7:0];
    end
    if (wr & is_reg(PADDR, prt_pkg::IDX_MASK)) begin
      next_mask = PWDATA[prt_pkg::ST_W-1:0];
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      mode_reg <= prt_pkg::RST_MODE;
      src_reg <= prt_pkg::RST_SRC;
      mask <= prt_pkg::RST_ST;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      mode_reg <= next_mode_reg;
      src_reg <= next_src_reg;
      mask <= next_mask;
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
    end
  end

  // Core: counters, pin, events
  always_comb begin
    logic sel_tick;
    logic ring_tick;
    logic t_f2;
    logic t_f8;
    logic cnt_tick;
    logic meas;
    logic uf;
    logic act_rise;
    logic act_fall;
    logic [prt_pkg::ST_W-1:0] set;
    logic [prt_pkg::ST_W-1:0] clr;
    sel_tick = 1'b0;
    cnt_tick = 1'b0;
    meas = 1'b0;
    uf = 1'b0;
    set = prt_pkg::RST_ST;
    clr = prt_pkg::RST_ST;
    next_pre_rl = pre_rl;
    next_pre_cnt = pre_cnt;
    next_tmr_rl = tmr_rl;
    next_tmr_cnt = tmr_cnt;
    next_cap = cap;
    next_tio_out = tio_out;
    next_div = div + 3'h1;
    next_act_d = act;
    t_f2 = div[0];
    t_f8 = (div == prt_pkg::DIV8_LAST);
    ring_tick = ring_s2 & ~ring_d;
    act_rise = act & ~act_d;
    act_fall = ~act & act_d;
    case (src_reg[prt_pkg::SRC_LSB +: 2])
      prt_pkg::SRC_F1: sel_tick = 1'b1;
      prt_pkg::SRC_F8: sel_tick = t_f8;
      prt_pkg::SRC_RING: sel_tick = ring_tick;
      prt_pkg::SRC_F2: sel_tick = t_f2;
      default: sel_tick = 1'b0;
    endcase
    case (mode)
      prt_pkg::MODE_TIMER: begin
        cnt_tick = run & sel_tick;
        meas = run & period & act_rise;
      end
      prt_pkg::MODE_PULSE: cnt_tick = run & sel_tick;
      prt_pkg::MODE_EVENT: cnt_tick = run & act_rise;
      prt_pkg::MODE_WIDTH: begin
        cnt_tick = run & sel_tick & act;
        meas = run & act_fall;
      end
      default: cnt_tick = 1'b0;
    endcase
    // Only the counting below waits for cnt_tick; capture, bus writes and status do not
    if (cnt_tick) begin
      if (pre_cnt == prt_pkg::CNT_ZERO) begin
        next_pre_cnt = pre_rl;
        if (tmr_cnt == prt_pkg::CNT_ZERO) begin
          next_tmr_cnt = tmr_rl;
          uf = 1'b1;
        end else begin
          next_tmr_cnt = tmr_cnt - 8'h01;
        end
      end else begin
        next_pre_cnt = pre_cnt - 8'h01;
      end
    end
    // Measurement restarts from the reload values after capture
    if (meas) begin
      next_cap = tmr_cnt;
      next_pre_cnt = pre_rl;
      next_tmr_cnt = tmr_rl;
    end
    // While running a write only reaches the reload register
    if (wr & is_reg(PADDR, prt_pkg::IDX_PRE)) begin
      next_pre_rl = PWDATA[7:0];
      if (~run) begin
        next_pre_cnt = PWDATA[7:0];
      end
    end
    if (wr & is_reg(PADDR, prt_pkg::IDX_TMR)) begin
      next_tmr_rl = PWDATA[7:0];
      if (~run) begin
        next_tmr_cnt = PWDATA[7:0];
      end
    end
    next_tio_oe = (mode == prt_pkg::MODE_PULSE);
    if (uf & (mode == prt_pkg::MODE_PULSE)) begin
      next_tio_out = ~tio_out;
    end
    set[prt_pkg::ST_UF] = uf;
    set[prt_pkg::ST_EXT] = act_rise;
    set[prt_pkg::ST_MEAS] = meas;
    if (wr & is_reg(PADDR, prt_pkg::IDX_STAT)) begin
      clr = PWDATA[prt_pkg::ST_W-1:0];
    end
    // Set beats a simultaneous clear
    next_status = (status & ~clr) | set;
    next_irq = |(next_status & mask);
    next_ext_irq = act_rise;
    next_uf_out = uf;
    case (src_reg[prt_pkg::SIB_LSB +: 2])
      prt_pkg::SRC_F1: next_sib_tick = 1'b1;
      prt_pkg::SRC_F8: next_sib_tick = t_f8;
      prt_pkg::SRC_RING: next_sib_tick = uf;
      prt_pkg::SRC_F2: next_sib_tick = t_f2;
      default: next_sib_tick = 1'b0;
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      pre_rl <= prt_pkg::RST_PRE;
      pre_cnt <= prt_pkg::RST_PRE;
      tmr_rl <= prt_pkg::RST_TMR;
      tmr_cnt <= prt_pkg::RST_TMR;
      cap <= prt_pkg::CNT_ZERO;
      status <= prt_pkg::RST_ST;
      div <= 3'h0;
      tio_s1 <= 1'b0;
      tio_s2 <= 1'b0;
      act_d <= 1'b0;
      ring_s1 <= 1'b0;
      ring_s2 <= 1'b0;
      ring_d <= 1'b0;
      tio_out <= 1'b0;
      tio_oe <= 1'b0;
      irq <= 1'b0;
      ext_irq <= 1'b0;
      uf_out <= 1'b0;
      sib_tick <= 1'b0;
    end else begin
      pre_rl <= next_pre_rl;
      pre_cnt <= next_pre_cnt;
      tmr_rl <= next_tmr_rl;
      tmr_cnt <= next_tmr_cnt;
      cap <= next_cap;
      status <= next_status;
      div <= next_div;
      tio_s1 <= TIO_IN;
      tio_s2 <= tio_s1;
      act_d <= next_act_d;
      ring_s1 <= RING_CLK;
      ring_s2 <= ring_s1;
      ring_d <= ring_s2;
      tio_out <= next_tio_out;
      tio_oe <= next_tio_oe;
      irq <= next_irq;
      ext_irq <= next_ext_irq;
      uf_out <= next_uf_out;
      sib_tick <= next_sib_tick;
    end
  end

  assign PRDATA = prdata;
  assign PREADY = pready;
  assign PSLVERR = pslverr;
  assign TIO_OUT = tio_out;
  assign TIO_OE = tio_oe;
  assign IRQ = irq;
  assign EXT_IRQ1 = ext_irq;
  assign UNDERFLOW = uf_out;
  assign SIB_SRC_TICK = sib_tick;
  assign SIB_SRC_SEL = src_reg[prt_pkg::SIB_LSB +: 2];

endmodule : prt_timer

//--- core/prt_pkg.sv
// Constants for the prescaled reload timer: register indices, fields, resets, codes.
// Assumes an APB master with 32-bit data; each register index maps to byte address 4*index.
package prt_pkg;
  localparam int ADDR_W = 12;
  localparam int CNT_W = 8;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_MODE = 8'h8b;
  localparam logic [7:0] IDX_PRE = 8'h8c;
  localparam logic [7:0] IDX_TMR = 8'h8d;
  localparam logic [7:0] IDX_SRC = 8'h8e;
  localparam logic [7:0] IDX_STAT = 8'h90;
  localparam logic [7:0] IDX_MASK = 8'h91;

  // Reset values
  localparam logic [7:0] RST_PRE = 8'hff;
  localparam logic [7:0] RST_TMR = 8'hff;
  localparam logic [7:0] RST_SRC = 8'h00;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [2:0] RST_ST = 3'h0;

  // Mode control fields
  localparam int MODE_LSB = 0;
  localparam int EDGE_BIT = 2;
  localparam int RUN_BIT = 3;
  localparam int PER_BIT = 7;

  // Source select fields
  localparam int SRC_LSB = 0;
  localparam int SIB_LSB = 4;

  // Operating modes
  localparam logic [1:0] MODE_TIMER = 2'h0;
  localparam logic [1:0] MODE_PULSE = 2'h1;
  localparam logic [1:0] MODE_EVENT = 2'h2;
  localparam logic [1:0] MODE_WIDTH = 2'h3;

  // Count source codes
  localparam logic [1:0] SRC_F1 = 2'h0;
  localparam logic [1:0] SRC_F8 = 2'h1;
  localparam logic [1:0] SRC_RING = 2'h2;
  localparam logic [1:0] SRC_F2 = 2'h3;

  // Status and mask bits
  localparam int ST_W = 3;
  localparam int ST_UF = 0;
  localparam int ST_EXT = 1;
  localparam int ST_MEAS = 2;

  localparam logic [2:0] DIV8_LAST = 3'h7;
  localparam logic [7:0] CNT_ZERO = 8'h00;
endpackage : prt_pkg

//--- verification/prt_timer_props.sv
// Assertions on the bus, pin and event ports of prt_timer.
// Assumes one clock MCLK and synchronous active-high SYS_RST.
`timescale 1ns/1ns
module prt_timer_props (
  // Clock and reset
  input wire logic MCLK,
  input wire logic SYS_RST,
  // Bus
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Pin and events
  input wire logic TIO_OUT,
  input wire logic TIO_OE,
  input wire logic EXT_IRQ1,
  input wire logic UNDERFLOW,
  input wire logic SIB_SRC_TICK,
  input wire logic [1:0] SIB_SRC_SEL
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  sequence s_acc;
    PSEL && PENABLE;
  endsequence
  sequence s_two_acc;
    s_acc ##1 s_acc;
  endsequence
  a_ready_second: assert property (s_two_acc |-> PREADY)
    else $error("ready missing in second access cycle");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready held too long");
  a_err_ready: assert property (PSLVERR |-> s_acc and PREADY)
    else $error("error flag outside a transfer end");
  a_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0)
    else $error("read data not zero between transfers");
  a_sib_every: assert property (SIB_SRC_SEL == 2'h0 && $past(SIB_SRC_SEL) == 2'h0
    && !$past(SYS_RST) |-> SIB_SRC_TICK) else $error("sibling tick missing");
  a_sib_chain: assert property (SIB_SRC_TICK && SIB_SRC_SEL == 2'h2
    && $past(SIB_SRC_SEL) == 2'h2 |-> UNDERFLOW || $past(UNDERFLOW))
    else $error("sibling tick without underflow");
  // Pin flips on the same edge that raises the underflow pulse, even back to back
  a_pin_toggle: assert property (UNDERFLOW && TIO_OE |-> TIO_OUT != $past(TIO_OUT))
    else $error("pin not inverted on underflow");
  a_ext_pulse: assert property (EXT_IRQ1 |=> !EXT_IRQ1)
    else $error("pin request longer than one cycle");
endmodule : prt_timer_props

bind prt_timer prt_timer_props u_props (.MCLK(MCLK), .SYS_RST(SYS_RST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .TIO_OUT(TIO_OUT), .TIO_OE(TIO_OE), .EXT_IRQ1(EXT_IRQ1), .UNDERFLOW(UNDERFLOW),
  .SIB_SRC_TICK(SIB_SRC_TICK), .SIB_SRC_SEL(SIB_SRC_SEL));

//--- verification/prt_pin_model.sv
// Far side of the timer pin: an external pulse source.
// Assumes pulse is called just after a rising MCLK edge.
`timescale 1ns/1ns
module prt_pin_model (
  // Clock
  input wire logic MCLK,
  // Pin
  input wire logic TIO_OUT,
  input wire logic TIO_OE,
  output logic TIO_IN
);
  logic lvl = 1'b0;
  // Timer wins the wire while it drives; otherwise the source level
  assign TIO_IN = TIO_OE ? TIO_OUT : lvl;
  task automatic pulse(input int hi, input int lo);
    lvl <= 1'b1;
    repeat (hi) @(posedge MCLK);
    lvl <= 1'b0;
    repeat (lo) @(posedge MCLK);
  endtask : pulse
endmodule : prt_pin_model

//--- verification/test_prescaled_reload_timer.sv
// Self-checking bench for prt_timer: APB tasks, pin source, ring clock.
// Assumes the pin model and checker are compiled first.
`timescale 1ns/1ns
module test_prescaled_reload_timer;
  logic MCLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [prt_pkg::ADDR_W-1:0] PADDR = '0;
  logic [31:0] PWDATA = '0;
  logic RING_CLK = 1'b0;
  logic [31:0] PRDATA;
  logic [1:0] SIB_SRC_SEL;
  logic PREADY, PSLVERR, TIO_IN, TIO_OUT, TIO_OE, IRQ, EXT_IRQ1, UNDERFLOW, SIB_SRC_TICK;
  logic [31:0] q;
  logic err, v;
  int n_fail = 0, compares = 0, n_uf = 0, n_ext = 0, g;
  int lo[4] = '{12, 96, 76, 24};
  int hi[4] = '{12, 96, 88, 24};
  logic [7:0] idx[3] = '{prt_pkg::IDX_PRE, prt_pkg::IDX_TMR, prt_pkg::IDX_SRC};
  logic [31:0] rv[3] = '{32'hff, 32'hff, 32'h0};

  initial forever #25 MCLK = ~MCLK;
  // Ring clock period 340 ns, no phase tie to MCLK
  initial forever #170 RING_CLK = ~RING_CLK;
  always @(posedge MCLK) begin
    if (UNDERFLOW === 1'b1) n_uf++;
    if (EXT_IRQ1 === 1'b1) n_ext++;
  end

  prt_timer DUT (.MCLK(MCLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .RING_CLK(RING_CLK), .TIO_IN(TIO_IN), .TIO_OUT(TIO_OUT),
    .TIO_OE(TIO_OE), .IRQ(IRQ), .EXT_IRQ1(EXT_IRQ1), .UNDERFLOW(UNDERFLOW),
    .SIB_SRC_TICK(SIB_SRC_TICK), .SIB_SRC_SEL(SIB_SRC_SEL));
  prt_pin_model pin (.MCLK(MCLK), .TIO_OUT(TIO_OUT), .TIO_OE(TIO_OE), .TIO_IN(TIO_IN));

  // Waits for ready however long it takes; only the watchdog ends a hang
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= {2'h0, a, 2'h0};
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge MCLK);
    end while (PREADY !== 1'b1);
    q = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge MCLK);
  endtask : acc

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic rng(input string nm, input int a, input int b, input logic [31:0] s);
    logic ok;
    ok = (s >= a && s <= b);
    compares++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("Error %s expected %0d..%0d seen %0d", nm, a, b, s);
    end
  endtask : rng

  task automatic wuf;
    do begin
      @(posedge MCLK);
    end while (UNDERFLOW !== 1'b1);
  endtask : wuf

  task automatic gap(output int n);
    wuf;
    n = 0;
    do begin
      @(posedge MCLK);
      n++;
    end while (UNDERFLOW !== 1'b1 && n < 400);
  endtask : gap

  task automatic conclude;
    $display("Compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  initial begin
    #(50 * 30000);
    n_fail++;
    conclude;
  end

  initial begin
    repeat (16) @(posedge MCLK);
    SYS_RST <= 1'b0;
    @(posedge MCLK);
    for (int i = 0; i < 3; i++) begin
      acc(1'b0, idx[i], 32'h0);
      chk("reset", rv[i], q);
    end
    acc(1'b0, 8'h8f, 32'h0);
    chk("slverr", 32'h1, 32'(err));
    acc(1'b1, prt_pkg::IDX_SRC, 32'h3c);
    acc(1'b0, prt_pkg::IDX_SRC, 32'h0);
    chk("src", 32'h3c, q);
    acc(1'b1, prt_pkg::IDX_PRE, 32'h2);
    acc(1'b1, prt_pkg::IDX_TMR, 32'h3);
    acc(1'b0, prt_pkg::IDX_PRE, 32'h0);
    chk("pre", 32'h2, q);
    acc(1'b0, prt_pkg::IDX_TMR, 32'h0);
    chk("tmr", 32'h3, q);
    acc(1'b1, prt_pkg::IDX_MASK, 32'h1);
    // Pin activity here must not disturb the plain timer
    fork
      repeat (30) pin.pulse(3, 4);
    join_none
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, prt_pkg::IDX_SRC, {26'h0, 2'h2, 2'h0, i[1:0]});
      acc(1'b1, prt_pkg::IDX_MODE, 32'h8);
      gap(g);
      rng("gap", lo[i], hi[i], 32'(g));
      acc(1'b1, prt_pkg::IDX_MODE, 32'h0);
    end
    chk("sibsel", 32'h2, 32'(SIB_SRC_SEL));
    chk("irq", 32'h1, 32'(IRQ));
    acc(1'b1, prt_pkg::IDX_STAT, 32'h1);
    @(posedge MCLK);
    chk("irqclr", 32'h0, 32'(IRQ));
    acc(1'b1, prt_pkg::IDX_SRC, 32'h0);
    acc(1'b1, prt_pkg::IDX_MODE, 32'h9);
    wuf;
    repeat (2) @(posedge MCLK);
    v = TIO_OUT;
    wuf;
    repeat (2) @(posedge MCLK);
    chk("pin", 32'(!v), 32'(TIO_OUT));
    chk("oe", 32'h1, 32'(TIO_OE));
    acc(1'b1, prt_pkg::IDX_MODE, 32'h0);
    acc(1'b1, prt_pkg::IDX_PRE, 32'h0);
    acc(1'b1, prt_pkg::IDX_TMR, 32'h2);
    acc(1'b1, prt_pkg::IDX_MODE, 32'ha);
    n_uf = 0;
    repeat (6) pin.pulse(4, 4);
    repeat (4) @(posedge MCLK);
    chk("events", 32'h2, 32'(n_uf));
    acc(1'b1, prt_pkg::IDX_MODE, 32'h0);
    acc(1'b1, prt_pkg::IDX_TMR, 32'hff);
    acc(1'b1, prt_pkg::IDX_MODE, 32'h88);
    repeat (3) pin.pulse(2, 38);
    acc(1'b0, prt_pkg::IDX_TMR, 32'h0);
    rng("period", 32'hd3, 32'hdb, q);
    acc(1'b1, prt_pkg::IDX_MODE, 32'hb);
    repeat (2) pin.pulse(20, 10);
    acc(1'b0, prt_pkg::IDX_TMR, 32'h0);
    rng("width", 32'he7, 32'hef, q);
    acc(1'b1, prt_pkg::IDX_MODE, 32'h0);
    n_ext = 0;
    acc(1'b1, prt_pkg::IDX_MODE, 32'h4);
    repeat (6) @(posedge MCLK);
    chk("spurious", 32'h1, 32'(n_ext));
    conclude;
  end
endmodule : test_prescaled_reload_timer
